// [dv/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
    n_mismatch++; end end

module tb;
    import vcag_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        host_index_wr = 1'b0;
    logic        host_data_wr = 1'b0;
    logic        host_data_rd = 1'b0;
    logic [7:0]  host_wdata = 8'h00;
    logic [7:0]  host_rdata;
    logic        attr_wr = 1'b0;
    logic        attr_wr_data = 1'b0;
    logic [1:0]  read_map_select = 2'h0;
    logic [31:0] read_latches = 32'h0;
    logic        char_tick = 1'b0;
    logic        hretrace_tick = 1'b0;
    logic        frame_start = 1'b0;
    logic [15:0] decoder_input_bits;
    logic [4:0]  row_scan_count;
    logic [9:0]  vert_count;
    logic        display_active;
    logic [9:0]  lc_tab [3] = '{10'h003, 10'h105, 10'h203};
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          seed = 41035;
    int          cycles = 0;

    always #2 clock = ~clock;

    vcag_top vcag_top_i (.clock(clock), .rst(rst),
        .host_index_wr(host_index_wr), .host_data_wr(host_data_wr),
        .host_data_rd(host_data_rd), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .attr_wr(attr_wr),
        .attr_wr_data(attr_wr_data), .read_map_select(read_map_select),
        .read_latches(read_latches), .char_tick(char_tick),
        .hretrace_tick(hretrace_tick), .frame_start(frame_start),
        .decoder_input_bits(decoder_input_bits),
        .row_scan_count(row_scan_count), .vert_count(vert_count),
        .display_active(display_active));

    function automatic logic [15:0] exp_reorg(logic [15:0] m,
        vcag_mode_t md, logic w, logic [1:0] rs, logic rss, logic cs);
        logic [15:0] o;
        case (md)
            VCAG_BYTE: o = m;
            VCAG_WORD: o = w ? {m[14:0], m[15]} : {m[14:0], m[13]};
            default:   o = {m[13:0], m[13], m[12]};
        endcase
        // Substitution comes after the shift, never before
        if (!rss) o[14] = rs[1];
        if (!cs) o[13] = rs[0];
        return o;
    endfunction

    task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
        @(negedge clock);
        host_index_wr = 1'b1;
        host_wdata = i;
        @(negedge clock);
        host_index_wr = 1'b0;
        host_data_wr = 1'b1;
        host_wdata = d;
        @(negedge clock);
        host_data_wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] i, output logic [7:0] d);
        @(negedge clock);
        host_index_wr = 1'b1;
        host_wdata = i;
        @(negedge clock);
        host_index_wr = 1'b0;
        host_data_rd = 1'b1;
        @(negedge clock);
        host_data_rd = 1'b0;
        @(negedge clock);
        d = host_rdata;
    endtask

    task automatic chars(input int n);
        repeat (n)
        begin
            @(negedge clock) char_tick = 1'b1;
            @(negedge clock) char_tick = 1'b0;
        end
    endtask

    task automatic retr(input int n);
        repeat (n)
        begin
            @(negedge clock) hretrace_tick = 1'b1;
            @(negedge clock) hretrace_tick = 1'b0;
        end
        repeat (3) @(negedge clock);
    endtask

    task automatic fstart();
        @(negedge clock) frame_start = 1'b1;
        @(negedge clock) frame_start = 1'b0;
        repeat (3) @(negedge clock);
    endtask

    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    initial
    begin
        logic [31:0] r;
        logic [7:0]  d;
        logic [7:0]  ul;
        logic [7:0]  mc;
        logic [15:0] base;
        logic [9:0]  lc;
        int          n;
        vcag_mode_t  md;
        repeat (20) @(negedge clock);
        rst = 1'b0;
        rd_reg(IDX_LATCH_VIEW, d);
        `CHK("latch_view_reset", 8'h00, d)
        rd_reg(IDX_TOGGLE, d);
        `CHK("toggle_reset", 8'h00, d)
        // Random sweep of every mode and substitution, through the top
        wr_reg(IDX_MAX_SCAN, 8'h1F);
        wr_reg(IDX_LINE_CMP, 8'hFF);
        repeat (300)
        begin
            r = $random(seed);
            md = vcag_mode_t'((r[17:16] == 2'b10) ? 2'b11 : r[17:16]);
            ul = {1'b0, md == VCAG_DWORD, 6'h00};
            mc = {1'b0, md == VCAG_BYTE, r[18], 3'h0, r[21], r[22]};
            wr_reg(IDX_START_HI, r[15:8]);
            wr_reg(IDX_START_LO, r[7:0]);
            wr_reg(IDX_UNDERLINE, ul);
            wr_reg(IDX_MODE_CTRL, mc);
            fstart();
            // Each undivided retrace step advances the row scan by one
            retr(int'(r[20:19]));
            base = exp_reorg(r[15:0], md, r[18], r[20:19], r[21], r[22]);
            `CHK("reorg", base, decoder_input_bits)
            `CHK("row_scan", {3'h0, r[20:19]}, row_scan_count)
        end
        $display("test reorg done");
        // Latch view, with a write attempt that must be ignored
        for (int k = 0; k < 8; k++)
        begin
            @(negedge clock);
            read_latches = $random(seed);
            read_map_select = k[1:0];
            if (k == 4) wr_reg(IDX_LATCH_VIEW, 8'hA5);
            rd_reg(IDX_LATCH_VIEW, d);
            `CHK("latch_view", read_latches[8*k[1:0] +: 8], d)
        end
        rd_reg(8'h3F, d);
        `CHK("unmapped", 8'h00, d)
        $display("test latch done");
        // Toggle flag follows the last attribute write, back to back too
        for (int k = 0; k < 6; k++)
        begin
            r = $random(seed);
            @(negedge clock) {attr_wr, attr_wr_data} = {1'b1, r[0]};
            @(negedge clock) attr_wr_data = r[1];
            // Read straight after the write: the flag must already show it
            @(negedge clock) {attr_wr, host_data_rd} = 2'b01;
            @(negedge clock) host_data_rd = 1'b0;
            if (k > 0)
                `CHK("toggle_now", {r[1], 7'h00}, host_rdata)
            if (k == 3) wr_reg(IDX_TOGGLE, 8'hFF);
            rd_reg(IDX_TOGGLE, d);
            `CHK("toggle", {r[1], 7'h00}, d)
        end
        $display("test toggle done");
        wr_reg(IDX_LINE_CMP, 8'h5A);
        rd_reg(IDX_LINE_CMP, d);
        `CHK("line_cmp_rw", 8'h5A, d)
        wr_reg(IDX_MODE_CTRL, 8'hFF);
        rd_reg(IDX_MODE_CTRL, d);
        `CHK("mode_ctrl_rw", 8'hEF, d)
        wr_reg(IDX_UNDERLINE, 8'hFF);
        rd_reg(IDX_UNDERLINE, d);
        `CHK("underline_rw", 8'h7F, d)
        // Addressing mode at the top, substitutions off
        wr_reg(IDX_START_HI, 8'h80);
        wr_reg(IDX_START_LO, 8'h01);
        wr_reg(IDX_OFFSET, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            ul = (k == 3) ? 8'h40 : 8'h00;
            mc = (k == 0) ? 8'h43 : (k == 1) ? 8'h63 : 8'h03;
            md = ul[6] ? VCAG_DWORD : mc[6] ? VCAG_BYTE : VCAG_WORD;
            wr_reg(IDX_UNDERLINE, ul);
            wr_reg(IDX_MODE_CTRL, mc);
            fstart();
            `CHK("mode_addr", exp_reorg(16'h8001, md, mc[5], 2'h0, 1'b1, 1'b1), decoder_input_bits)
        end
        $display("test mode done");
        // Increment interval: over 8 ticks any start phase gives 8/n steps
        wr_reg(IDX_START_HI, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            n = k[1] ? (k[0] ? 2 : 4) : (k[0] ? 2 : 1);
            wr_reg(IDX_UNDERLINE, {2'b00, k[1], 5'h00});
            wr_reg(IDX_MODE_CTRL, {4'h4, k[0], 3'h3});
            fstart();
            base = decoder_input_bits;
            chars(8);
            repeat (3) @(negedge clock);
            `CHK("ma_step", 16'(8 / n), 16'(decoder_input_bits - base))
        end
        $display("test count done");
        // Vertical counter clocked by retrace, optionally halved
        for (int k = 0; k < 2; k++)
        begin
            wr_reg(IDX_MODE_CTRL, k[0] ? 8'h47 : 8'h43);
            fstart();
            retr(6);
            `CHK("vert_count", k[0] ? 10'd3 : 10'd6, vert_count)
        end
        $display("test vertical done");
        // Split screen: start address above the compare line, zero on it
        wr_reg(IDX_MODE_CTRL, 8'h43);
        wr_reg(IDX_UNDERLINE, 8'h00);
        wr_reg(IDX_START_HI, 8'h01);
        wr_reg(IDX_START_LO, 8'h23);
        wr_reg(IDX_VDE_END, 8'hFF);
        foreach (lc_tab[j])
        begin
            lc = lc_tab[j];
            wr_reg(IDX_OVERFLOW, {1'b1, 1'b0, 1'b0, lc[8], 4'h2});
            wr_reg(IDX_MAX_SCAN, {1'b0, lc[9], 6'h1F});
            wr_reg(IDX_LINE_CMP, lc[7:0]);
            fstart();
            retr(int'(lc) - 1);
            `CHK("above_split", 16'h0123, decoder_input_bits)
            `CHK("active", lc <= 10'h200, display_active)
            retr(1);
            `CHK("split_line", 16'h0000, decoder_input_bits)
        end
        $display("test split done");
        test_done();
    end

endmodule // tb
`undef CHK
`default_nettype wire

// [rtl/vcag_addr_reorg.sv]
`timescale 1ns/10ps
`default_nettype none
module vcag_addr_reorg
(
    input  wire logic [15:0]          ma,
    input  wire vcag_pkg::vcag_mode_t mode,
    input  wire logic                 addr_wrap,
    input  wire logic [1:0]           row_scan,
    input  wire logic                 row_scan_sel,
    input  wire logic                 compat_sel,
    output logic      [15:0]          decoder_in
);
    import vcag_pkg::*;

    logic [15:0] reorganised_address_bits;

    always_comb
    begin
        unique case (mode)
            VCAG_BYTE:  reorganised_address_bits = ma;
            // Wrap clear feeds bit 13 back in, folding at 16 KB
            VCAG_WORD:  reorganised_address_bits = addr_wrap ?
                            {ma[14:0], ma[15]} :
                            {ma[14:0], ma[13]};
            VCAG_DWORD: reorganised_address_bits =
                            {ma[13:0], ma[13], ma[12]};
            default:    reorganised_address_bits = ma;
        endcase
    end

    // Substitution acts on the already reorganised bits
    always_comb
    begin
        decoder_in = reorganised_address_bits;
        if (!row_scan_sel)
        begin
            decoder_in[SUB_ROW_ONE_POS] = row_scan[1];
        end
        if (!compat_sel)
        begin
            decoder_in[SUB_ROW_ZERO_POS] = row_scan[0];
        end
    end

endmodule // vcag_addr_reorg
`default_nettype wire

// [rtl/vcag_top.sv]
`timescale 1ns/10ps
`default_nettype none
module vcag_top
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        host_index_wr,
    input  wire logic        host_data_wr,
    input  wire logic        host_data_rd,
    input  wire logic [7:0]  host_wdata,
    output logic      [7:0]  host_rdata,
    input  wire logic        attr_wr,
    input  wire logic        attr_wr_data,
    input  wire logic [1:0]  read_map_select,
    input  wire logic [31:0] read_latches,
    input  wire logic        char_tick,
    input  wire logic        hretrace_tick,
    input  wire logic        frame_start,
    output logic      [15:0] decoder_input_bits,
    output logic      [4:0]  row_scan_count,
    output logic      [9:0]  vert_count,
    output logic             display_active
);
    import vcag_pkg::*;

    function automatic logic [1:0] last_tick(input logic by4,
                                             input logic by2);
        if (by2)
        begin
            return 2'h1;
        end
        else if (by4)
        begin
            return 2'h3;
        end
        return 2'h0;
    endfunction

    function automatic vcag_mode_t mode_of(input logic dword,
                                           input logic word_byte);
        if (dword)
        begin
            return VCAG_DWORD;
        end
        return word_byte ? VCAG_BYTE : VCAG_WORD;
    endfunction

    // Register file, reached through index and data ports
    logic [7:0]  index_q,      index_d;
    logic [7:0]  overflow_q,   overflow_d;
    logic [7:0]  max_scan_q,   max_scan_d;
    logic [7:0]  start_hi_q,   start_hi_d;
    logic [7:0]  start_lo_q,   start_lo_d;
    logic [7:0]  vde_end_q,    vde_end_d;
    logic [7:0]  offset_q,     offset_d;
    logic [7:0]  underline_q,  underline_d;
    logic [7:0]  mode_ctrl_q,  mode_ctrl_d;
    logic [7:0]  line_cmp_q,   line_cmp_d;
    logic        toggle_q,     toggle_d;
    logic [7:0]  rdata_q,      rdata_d;
    logic [7:0]  latch_byte;

    assign latch_byte = read_latches[8*read_map_select +: 8];

    always_comb
    begin
        index_d     = index_q;
        overflow_d  = overflow_q;
        max_scan_d  = max_scan_q;
        start_hi_d  = start_hi_q;
        start_lo_d  = start_lo_q;
        vde_end_d   = vde_end_q;
        offset_d    = offset_q;
        underline_d = underline_q;
        mode_ctrl_d = mode_ctrl_q;
        line_cmp_d  = line_cmp_q;
        toggle_d    = toggle_q;
        rdata_d     = rdata_q;
        if (host_index_wr)
        begin
            index_d = host_wdata;
        end
        if (host_data_wr)
        begin
            case (index_q)
                IDX_OVERFLOW:  overflow_d  = host_wdata;
                IDX_MAX_SCAN:  max_scan_d  = host_wdata;
                IDX_START_HI:  start_hi_d  = host_wdata;
                IDX_START_LO:  start_lo_d  = host_wdata;
                IDX_VDE_END:   vde_end_d   = host_wdata;
                IDX_OFFSET:    offset_d    = host_wdata;
                IDX_UNDERLINE: underline_d = host_wdata & UL_WMASK;
                IDX_MODE_CTRL: mode_ctrl_d = host_wdata & MC_WMASK;
                IDX_LINE_CMP:  line_cmp_d  = host_wdata;
                default:       ;
            endcase
        end
        // Attribute side owns the flip-flop; we only mirror its last port
        if (attr_wr)
        begin
            toggle_d = attr_wr_data;
        end
        if (host_data_rd)
        begin
            case (index_q)
                IDX_OVERFLOW:   rdata_d = overflow_q;
                IDX_MAX_SCAN:   rdata_d = max_scan_q;
                IDX_START_HI:   rdata_d = start_hi_q;
                IDX_START_LO:   rdata_d = start_lo_q;
                IDX_VDE_END:    rdata_d = vde_end_q;
                IDX_OFFSET:     rdata_d = offset_q;
                IDX_UNDERLINE:  rdata_d = underline_q;
                IDX_MODE_CTRL:  rdata_d = mode_ctrl_q;
                IDX_LINE_CMP:   rdata_d = line_cmp_q;
                IDX_LATCH_VIEW: rdata_d = latch_byte;
                IDX_TOGGLE:     rdata_d = {toggle_q, 7'h00};
                default:        rdata_d = REG_RST;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            index_q     <= REG_RST;
            overflow_q  <= REG_RST;
            max_scan_q  <= REG_RST;
            start_hi_q  <= REG_RST;
            start_lo_q  <= REG_RST;
            vde_end_q   <= REG_RST;
            offset_q    <= REG_RST;
            underline_q <= REG_RST;
            mode_ctrl_q <= REG_RST;
            line_cmp_q  <= REG_RST;
            toggle_q    <= 1'b0;
            rdata_q     <= REG_RST;
        end
        else
        begin
            index_q     <= index_d;
            overflow_q  <= overflow_d;
            max_scan_q  <= max_scan_d;
            start_hi_q  <= start_hi_d;
            start_lo_q  <= start_lo_d;
            vde_end_q   <= vde_end_d;
            offset_q    <= offset_d;
            underline_q <= underline_d;
            mode_ctrl_q <= mode_ctrl_d;
            line_cmp_q  <= line_cmp_d;
            toggle_q    <= toggle_d;
            rdata_q     <= rdata_d;
        end
    end

    assign host_rdata = rdata_q;

    // Scan timing and memory address counter
    logic [15:0] ma_q,        ma_d;
    logic [15:0] row_start_q, row_start_d;
    logic [1:0]  chr_q,       chr_d;
    logic        div_q,       div_d;
    logic [9:0]  vcount_q,    vcount_d;
    logic [4:0]  row_scan_q,  row_scan_d;
    logic [15:0] fb_q,        fb_d;
    logic        active_q,    active_d;
    logic [9:0]  vnext;
    logic [9:0]  line_cmp;
    logic [9:0]  vde_end;
    logic [15:0] start_addr;
    logic [15:0] next_row;
    logic        vt_step;
    vcag_mode_t  mode;

    assign line_cmp = {max_scan_q[MSL_LC_BIT9], overflow_q[OVF_LC_BIT8],
                       line_cmp_q};
    assign vde_end    = {overflow_q[OVF_VDE_BIT9], overflow_q[OVF_VDE_BIT8],
                         vde_end_q};
    assign start_addr = {start_hi_q, start_lo_q};
    assign next_row   = row_start_q + {7'h00, offset_q, 1'b0};
    assign vnext      = vcount_q + 10'h001;
    assign mode       = mode_of(underline_q[UL_DWORD],
                                mode_ctrl_q[MC_WORD_BYTE]);
    // Divided mode lets every second retrace tick through
    assign vt_step    = hretrace_tick &
                        (~mode_ctrl_q[MC_HR_DIV] | div_q);

    always_comb
    begin
        ma_d        = ma_q;
        row_start_d = row_start_q;
        chr_d       = chr_q;
        div_d       = div_q;
        vcount_d    = vcount_q;
        row_scan_d  = row_scan_q;
        if (hretrace_tick)
        begin
            div_d = ~div_q;
        end
        if (frame_start)
        begin
            vcount_d    = 10'h000;
            row_scan_d  = 5'h00;
            row_start_d = start_addr;
            ma_d        = start_addr;
            chr_d       = 2'h0;
            div_d       = 1'b0;
        end
        else if (vt_step)
        begin
            vcount_d = vnext;
            chr_d    = 2'h0;
            // Compare hit wins over row advance: lower part starts at 0
            if (vnext == line_cmp)
            begin
                row_start_d = 16'h0000;
                ma_d        = 16'h0000;
                row_scan_d  = 5'h00;
            end
            else if (row_scan_q == max_scan_q[ROW_W-1:0])
            begin
                row_scan_d  = 5'h00;
                row_start_d = next_row;
                ma_d        = next_row;
            end
            else
            begin
                row_scan_d = row_scan_q + 5'h01;
                ma_d       = row_start_q;
            end
        end
        else if (hretrace_tick)
        begin
            ma_d  = row_start_q;
            chr_d = 2'h0;
        end
        else if (char_tick)
        begin
            // A mode change mid-interval must not leave the phase stranded
            if (chr_q >= last_tick(underline_q[UL_COUNT_BY_FOUR],
                                   mode_ctrl_q[MC_COUNT_BY_TWO]))
            begin
                chr_d = 2'h0;
                ma_d  = ma_q + 16'h0001;
            end
            else
            begin
                chr_d = chr_q + 2'h1;
            end
        end
        active_d = (vcount_d <= vde_end);
    end

    vcag_addr_reorg u_reorg
    (
        .ma           (ma_q),
        .mode         (mode),
        .addr_wrap    (mode_ctrl_q[MC_ADDR_WRAP]),
        .row_scan     (row_scan_q[1:0]),
        .row_scan_sel (mode_ctrl_q[MC_ROW_SCAN_SEL]),
        .compat_sel   (mode_ctrl_q[MC_COMPAT]),
        .decoder_in   (fb_d)
    );

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ma_q        <= 16'h0000;
            row_start_q <= 16'h0000;
            chr_q       <= 2'h0;
            div_q       <= 1'b0;
            vcount_q    <= 10'h000;
            row_scan_q  <= 5'h00;
            fb_q        <= 16'h0000;
            active_q    <= 1'b0;
        end
        else
        begin
            ma_q        <= ma_d;
            row_start_q <= row_start_d;
            chr_q       <= chr_d;
            div_q       <= div_d;
            vcount_q    <= vcount_d;
            row_scan_q  <= row_scan_d;
            fb_q        <= fb_d;
            active_q    <= active_d;
        end
    end

    assign decoder_input_bits = fb_q;
    assign row_scan_count     = row_scan_q;
    assign vert_count         = vcount_q;
    assign display_active     = active_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_quiet_tick;
        char_tick && !hretrace_tick && !frame_start;
    endsequence

    sequence s_compare_hit;
        !frame_start && vt_step && (vnext == line_cmp);
    endsequence

    a_ma_step_one: assert property (
        s_quiet_tick and (!underline_q[UL_COUNT_BY_FOUR] &&
                          !mode_ctrl_q[MC_COUNT_BY_TWO])
        |=> ma_q == $past(ma_q) + 16'h0001)
        else $error("address counter missed a single-tick step");

    a_ma_hold_four: assert property (
        s_quiet_tick and (underline_q[UL_COUNT_BY_FOUR] &&
                          !mode_ctrl_q[MC_COUNT_BY_TWO] && chr_q != 2'h3)
        |=> $stable(ma_q))
        else $error("address counter stepped early in count-by-four");

    a_vt_div_two: assert property (
        hretrace_tick && mode_ctrl_q[MC_HR_DIV] && !div_q && !frame_start
        |=> $stable(vert_count))
        else $error("vertical counter stepped on a skipped retrace");

    a_row_sub_one: assert property (
        !mode_ctrl_q[MC_ROW_SCAN_SEL]
        |=> decoder_input_bits[SUB_ROW_ONE_POS] == $past(row_scan_q[1]))
        else $error("bit 14 not taken from row scan bit 1");

    a_row_sub_zero: assert property (
        !mode_ctrl_q[MC_COMPAT]
        |=> decoder_input_bits[SUB_ROW_ZERO_POS] == $past(row_scan_q[0]))
        else $error("bit 13 not taken from row scan bit 0");

    a_word_wrap_bit: assert property (
        mode == VCAG_WORD && !mode_ctrl_q[MC_ADDR_WRAP]
        |=> decoder_input_bits[0] == $past(ma_q[13])
            && decoder_input_bits[1] == $past(ma_q[0]))
        else $error("word mode wrap mapping wrong");

    a_dword_shift: assert property (
        underline_q[UL_DWORD]
        |=> decoder_input_bits[1:0] == $past({ma_q[13], ma_q[12]}))
        else $error("doubleword mapping wrong");

    a_split_restart: assert property (
        s_compare_hit |=> (ma_q == 16'h0000) ##1
                          (decoder_input_bits[12:0] == 13'h0000))
        else $error("line compare did not restart address at zero");

    a_frame_start: assert property (
        frame_start |=> ma_q == $past(start_addr))
        else $error("frame did not start at the start address");

    a_latch_read: assert property (
        host_data_rd && index_q == IDX_LATCH_VIEW
        |=> host_rdata == $past(latch_byte))
        else $error("latch view returned wrong byte");

    a_toggle_track: assert property (
        attr_wr ##1 (host_data_rd && index_q == IDX_TOGGLE && !attr_wr)
        |=> host_rdata == {$past(attr_wr_data, 2), 7'h00})
        else $error("toggle status does not follow last attribute write");

endmodule // vcag_top
`default_nettype wire

// [shared/vcag_pkg.sv]
// How it works
// - Address counter steps every 1, 2 or 4 character ticks per count bits.
// - Vertical counter steps per retrace tick, or every second one when divided.
// - With row scan select clear, address bit 14 takes row scan bit 1.
// - With compatibility select clear, address bit 13 takes row scan bit 0.
// - Byte passes, word shifts left by one (bit 0 from bit 15, or 13), doubleword shifts left by two (bits 1:0 from bits 13:12).
// - Reorganise first, then substitute row scan bits; others pass straight.
// - Address counter restarts at zero on the line compare scan line.
// - Line compare is ten bits from three registers.
// - A compare inside active display splits the screen at that line.
// - Lines above the compare line start at the start address.
// - Latch view reads one of four latches chosen by read map select.
// - Toggle status bit 7 shows last attribute write port; others read zero.
// - Doubleword bit wins; otherwise word/byte bit picks byte or word.
// - Word mode with wrap bit clear wraps addresses at 16 KB.
package vcag_pkg;

    localparam int          REG_W            = 8;
    localparam int          ADDR_W           = 16;
    localparam int          VCNT_W           = 10;
    localparam int          ROW_W            = 5;

    localparam logic [7:0]  IDX_OVERFLOW     = 8'h07;
    localparam logic [7:0]  IDX_MAX_SCAN     = 8'h09;
    localparam logic [7:0]  IDX_START_HI     = 8'h0C;
    localparam logic [7:0]  IDX_START_LO     = 8'h0D;
    localparam logic [7:0]  IDX_VDE_END      = 8'h12;
    localparam logic [7:0]  IDX_OFFSET       = 8'h13;
    localparam logic [7:0]  IDX_UNDERLINE    = 8'h14;
    localparam logic [7:0]  IDX_MODE_CTRL    = 8'h17;
    localparam logic [7:0]  IDX_LINE_CMP     = 8'h18;
    localparam logic [7:0]  IDX_LATCH_VIEW   = 8'h22;
    localparam logic [7:0]  IDX_TOGGLE       = 8'h24;

    localparam int          MC_COMPAT        = 0;
    localparam int          MC_ROW_SCAN_SEL  = 1;
    localparam int          MC_HR_DIV        = 2;
    localparam int          MC_COUNT_BY_TWO  = 3;
    localparam int          MC_ADDR_WRAP     = 5;
    localparam int          MC_WORD_BYTE     = 6;
    localparam int          UL_COUNT_BY_FOUR = 5;
    localparam int          UL_DWORD         = 6;
    localparam int          MSL_LC_BIT9      = 6;
    localparam int          OVF_LC_BIT8      = 4;
    localparam int          OVF_VDE_BIT8     = 1;
    localparam int          OVF_VDE_BIT9     = 6;
    localparam int          TOGGLE_BIT       = 7;
    localparam int          SUB_ROW_ONE_POS  = 14;
    localparam int          SUB_ROW_ZERO_POS = 13;

    localparam logic [7:0]  UL_WMASK         = 8'h7F;
    localparam logic [7:0]  MC_WMASK         = 8'hEF;
    localparam logic [7:0]  REG_RST          = 8'h00;

    typedef enum logic [1:0] {
        VCAG_BYTE  = 2'b00,
        VCAG_WORD  = 2'b01,
        VCAG_DWORD = 2'b11
    } vcag_mode_t;

endpackage
